/* File: logic/niec_cfg.svh */
// Offsets, field positions and reset values of the interrupt block
`ifndef NIEC_CFG_SVH
`define NIEC_CFG_SVH
// Register offsets
`define NIEC_OFS_CTRL   8'he6
`define NIEC_OFS_EDGE   8'hf2
`define NIEC_OFS_PEND   8'hf3
`define NIEC_OFS_MASK   8'hf4
`define NIEC_OFS_PRIO   8'hf5
`define NIEC_OFS_NEST   8'hf7
`define NIEC_OFS_SRC    8'hf8
`define NIEC_OFS_ISEG   8'hf9
`define NIEC_OFS_VEC    8'hfa
`define NIEC_OFS_CSEG   8'hfb
// Central control fields
`define NIEC_CTRL_IEN   4
`define NIEC_CTRL_IAM   3
// Source-select fields
`define NIEC_SRC_A0S    0
`define NIEC_SRC_TSEL   1
`define NIEC_SRC_SERIAL_PERIPH_ENABLE   2
`define NIEC_SRC_BMS    3
`define NIEC_SRC_ADSEL  4
`define NIEC_SRC_VBSEL  5
`define NIEC_SRC_FIELD_START_ENABLE  6
`define NIEC_SRC_EXTENDED_CONTEXT_BIT  7
// Reset values
`define NIEC_RST_CPL    3'h7
`define NIEC_RST_SRC    8'h03
`define NIEC_RST_ZERO   8'h00
`endif

/* File: logic/niec_pkg.sv */
// Types shared by the interrupt block
`default_nettype none
package niec_pkg;
    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } niec_bus_s;
    // Sequencer states
    typedef enum logic [3:0] {
        SQ_IDLE    = 4'h0,
        SQ_PSH_PCL = 4'h1,
        SQ_PSH_PCH = 4'h2,
        SQ_PSH_CSR = 4'h3,
        SQ_PSH_FLG = 4'h4,
        SQ_VEC_RD  = 4'h5,
        SQ_VEC_WT  = 4'h6,
        SQ_VEC_LD  = 4'h7,
        SQ_POP_FLG = 4'h8,
        SQ_POP_CSR = 4'h9,
        SQ_POP_PCH = 4'ha,
        SQ_POP_PCL = 4'hb,
        SQ_POP_WT  = 4'hc,
        SQ_RET_FIN = 4'hd
    } niec_state_e;
    // Kind of byte being popped
    typedef enum logic [2:0] {
        PK_NONE = 3'h0,
        PK_FLG  = 3'h1,
        PK_CSR  = 3'h2,
        PK_PCH  = 3'h3,
        PK_PCL  = 3'h4
    } niec_pop_e;
endpackage
`default_nettype wire

/* File: logic/niec_top.sv */
// Nested interrupt sequencer and eight external interrupt channels
//
// Functional notes
// - Nested ack sets stack bit at current level
// - Nested ack loads level with request priority
// - Entry: disable, save, load, push, vector
// - Extended context loads segment, else swaps
// - Return pops flags, segment, PC, enables
// - Nested return restores level from stack
// - Plain return swaps segment unless still nested
// - Eight pins map to A0 through D1
// - Edge select picks rising or falling
// - Edge and pending bits ordered A0 first
// - Mask bits run bit7 A0 to bit0 D1
// - Pair priority: even level, odd next
// - A0 source pin or watchdog by select
// - Timer select zero routes timers to A1, D0
// - B0 pin only when serial and bus zero
// - B1 converter done when select set
// - C0 blanking end when sync bit set
// - C1 field start when enable set
// - D1 always from pin 7
// - Acknowledge only if priority below level
// - Level 7 requests never acknowledged
// - Mode bit picks concurrent or nested
// - Equal priority: daisy chain A0 first
`include "niec_cfg.svh"
`default_nettype none
module niec_top #(
    parameter int NUM_CH = 8
) (
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    // Register port
    input  wire niec_pkg::niec_bus_s bus_req,
    output logic [7:0]              bus_rdata,
    // External pins and internal sources
    input  wire logic [7:0]         ext_pin,
    input  wire logic               wdt_irq,
    input  wire logic               tim0_irq,
    input  wire logic               tim1_irq,
    input  wire logic               spi_irq,
    input  wire logic               adc_irq,
    input  wire logic               end_of_vertical_blanking,
    input  wire logic               field_start_event,
    // CPU sequencer handshake
    input  wire logic               cpu_accept,
    input  wire logic               cpu_iret,
    input  wire logic [15:0]        cpu_pc,
    input  wire logic [7:0]         cpu_flags,
    output logic                    irq_req,
    output logic                    seq_busy,
    // Stack port
    output logic                    stack_wr,
    output logic                    stack_rd,
    output logic [7:0]              stack_wdata,
    input  wire logic [7:0]         stack_rdata,
    // Vector table port
    output logic                    vec_rd,
    output logic [7:0]              vec_addr,
    input  wire logic [15:0]        vec_rdata,
    // Context loads
    output logic                    pc_load,
    output logic [15:0]             pc_value,
    output logic                    flags_load,
    output logic [7:0]              flags_value,
    output logic [7:0]              exec_segment
);
    import niec_pkg::*;

    // Only the documented channel count is served
    if (NUM_CH != 8) begin : g_bad_ch
        $error("niec_top serves exactly eight channels");
    end

    // Software registers
    logic [7:0]  edge_sel_q;        // ext_edge_select
    logic [7:0]  pend_q;            // ext_pending_flags
    logic [7:0]  pend_d;            // Next pending flags
    logic [7:0]  mask_q;            // ext_mask_bits
    logic [7:0]  prio_q;            // ext_pair_priority
    logic [7:0]  nest_q;            // Nesting stack, one-hot per level
    logic [7:0]  src_q;             // Source selects and context bit
    logic [7:0]  iseg_q;            // Interrupt segment
    logic [7:0]  ivr_q;             // Vector register
    logic [7:0]  cseg_q;            // Code segment
    logic        ien_q;             // Global enable
    logic        iam_q;             // Arbitration mode, 1 = nested
    logic [2:0]  cpl_q;             // Current priority level
    // Pin sync, edge detect and arbitration
    logic [7:0]  pin_s1_q;          // First sync stage only
    logic [7:0]  pin_s2_q;          // Synchronised pins
    logic [7:0]  src_prev_q;        // Previous channel source level
    logic [7:0]  src_now;           // Selected channel source
    logic [7:0]  edge_hit;          // Trigger event this cycle
    logic [2:0]  ch_prl [8];        // Priority per channel
    logic        win_vld;           // Some channel requesting
    logic [2:0]  win_ch;            // Winning channel
    logic [2:0]  win_prl;           // Winning priority
    logic [2:0]  tk_ch_q;           // Channel taken
    // Sequencer
    niec_state_e st_q;              // Sequencer state
    niec_pop_e   pk_q;              // Pop kind beside strobe
    niec_pop_e   pk2_q;             // Pop kind beside data
    logic [15:0] pc_sav_q;          // PC captured at entry
    logic [7:0]  flg_sav_q;         // Flags captured at entry
    logic [7:0]  pch_q;             // Popped PC high byte
    logic [3:0]  depth_q;           // Routines in service
    logic        use_iseg_q;        // Interrupt segment in place of code segment
    logic        take;              // Entry starts this cycle
    logic        ret;               // Return starts this cycle
    logic        wr_ctrl;           // Software writes central control
    logic        extended_context_bit;             // Extended context selected
    logic [2:0]  low_nest;          // Lowest set stack bit

    assign take    = cpu_accept && irq_req && (st_q == SQ_IDLE);
    assign ret     = cpu_iret && (st_q == SQ_IDLE) && !cpu_accept;
    assign wr_ctrl = bus_req.wr && (bus_req.addr == `NIEC_OFS_CTRL);
    assign extended_context_bit   = src_q[`NIEC_SRC_EXTENDED_CONTEXT_BIT];

    // Two-flop pin synchroniser; stage one feeds stage two only
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pin_s1_q <= `NIEC_RST_ZERO;
            pin_s2_q <= `NIEC_RST_ZERO;
        end else begin
            pin_s1_q <= ext_pin;
            pin_s2_q <= pin_s1_q;
        end
    end

    // Source muxing per channel, A0 at index 0
    always_comb begin
        src_now[0] = src_q[`NIEC_SRC_A0S] ? pin_s2_q[0] : wdt_irq;
        src_now[1] = src_q[`NIEC_SRC_TSEL] ? pin_s2_q[1] : tim0_irq;
        src_now[2] = (!src_q[`NIEC_SRC_SERIAL_PERIPH_ENABLE] && !src_q[`NIEC_SRC_BMS]) ? pin_s2_q[2] : spi_irq;
        src_now[3] = src_q[`NIEC_SRC_ADSEL] ? adc_irq : pin_s2_q[3];
        src_now[4] = src_q[`NIEC_SRC_VBSEL] ? end_of_vertical_blanking : pin_s2_q[4];
        src_now[5] = src_q[`NIEC_SRC_FIELD_START_ENABLE] ? field_start_event : pin_s2_q[5];
        src_now[6] = src_q[`NIEC_SRC_TSEL] ? pin_s2_q[6] : tim1_irq;
        src_now[7] = pin_s2_q[7];
    end

    // Edge detect and priority per channel
    for (genvar i = 0; i < 8; i++) begin : g_ch
        // Rising when select is one, falling when zero
        assign edge_hit[i] = edge_sel_q[i] ? (src_now[i] && !src_prev_q[i])
                                           : (!src_now[i] && src_prev_q[i]);
        // Pair field from the top, odd channel one level lower
        assign ch_prl[i] = {prio_q[7 - 2 * (i / 2)], prio_q[6 - 2 * (i / 2)], 1'(i % 2)};
    end

    // Previous source level; a mux change may look like an edge
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            src_prev_q <= `NIEC_RST_ZERO;
        end else begin
            src_prev_q <= src_now;
        end
    end

    // Lowest priority value wins, earliest channel on a tie
    always_comb begin
        win_vld = 1'b0;
        win_ch  = 3'h0;
        win_prl = 3'h7;
        for (int i = 0; i < 8; i++) begin
            // Mask bit 7 belongs to A0
            if (pend_q[i] && mask_q[7 - i] && (!win_vld || ch_prl[i] < win_prl)) begin
                win_vld = 1'b1;
                win_ch  = 3'(i);
                win_prl = ch_prl[i];
            end
        end
    end

    // Lowest set bit of the nesting stack
    always_comb begin
        low_nest = 3'h7;
        for (int i = 7; i >= 0; i--) begin
            if (nest_q[i]) begin
                low_nest = 3'(i);
            end
        end
    end

    // Request flag toward the CPU, blocked while sequencing
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq_req <= 1'b0;
        end else begin
            // Strict compare keeps level 7 out for good
            irq_req <= win_vld && ien_q && (win_prl < cpl_q) && (st_q == SQ_IDLE) && !take;
        end
    end

    // Edge, mask, priority, source, interrupt segment and vector registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            edge_sel_q <= `NIEC_RST_ZERO;
            mask_q     <= `NIEC_RST_ZERO;
            prio_q     <= `NIEC_RST_ZERO;
            src_q      <= `NIEC_RST_SRC;
            iseg_q     <= `NIEC_RST_ZERO;
            ivr_q      <= `NIEC_RST_ZERO;
        end else if (bus_req.wr) begin
            unique case (bus_req.addr)
                `NIEC_OFS_EDGE: edge_sel_q <= bus_req.wdata;
                `NIEC_OFS_MASK: mask_q     <= bus_req.wdata;
                `NIEC_OFS_PRIO: prio_q     <= bus_req.wdata;
                `NIEC_OFS_SRC:  src_q      <= bus_req.wdata;
                `NIEC_OFS_ISEG: iseg_q     <= bus_req.wdata;
                `NIEC_OFS_VEC:  ivr_q      <= bus_req.wdata;
                default: ;
            endcase
        end
    end

    // Pending flags; an edge wins over any clear in the same cycle
    always_comb begin
        pend_d = pend_q;
        // Hardware clears the winner on acknowledge
        if (take) begin
            pend_d[win_ch] = 1'b0;
        end
        if (bus_req.wr && bus_req.addr == `NIEC_OFS_PEND) begin
            pend_d = bus_req.wdata;
        end
        pend_d = pend_d | edge_hit;
    end

    // Pending register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pend_q <= `NIEC_RST_ZERO;
        end else begin
            pend_q <= pend_d;
        end
    end

    // Central control: enable, mode, level
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ien_q <= 1'b0;
            iam_q <= 1'b0;
            cpl_q <= `NIEC_RST_CPL;
        end else if (take) begin
            ien_q <= 1'b0;
            if (iam_q) begin
                cpl_q <= win_prl;
            end
        end else if (st_q == SQ_RET_FIN) begin
            ien_q <= 1'b1;
            if (iam_q && nest_q != `NIEC_RST_ZERO) begin
                cpl_q <= low_nest;
            end
        end else if (wr_ctrl) begin
            ien_q <= bus_req.wdata[`NIEC_CTRL_IEN];
            iam_q <= bus_req.wdata[`NIEC_CTRL_IAM];
            cpl_q <= bus_req.wdata[2:0];
        end
    end

    // Nesting stack register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            nest_q <= `NIEC_RST_ZERO;
        end else if (take && iam_q) begin
            nest_q[cpl_q] <= 1'b1;
        end else if (st_q == SQ_RET_FIN && iam_q && nest_q != `NIEC_RST_ZERO) begin
            nest_q[low_nest] <= 1'b0;
        end else if (bus_req.wr && bus_req.addr == `NIEC_OFS_NEST) begin
            nest_q <= bus_req.wdata;
        end
    end

    // Capture what entry must push
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pc_sav_q  <= 16'h0000;
            flg_sav_q <= `NIEC_RST_ZERO;
            tk_ch_q   <= 3'h0;
        end else if (take) begin
            pc_sav_q  <= cpu_pc;
            flg_sav_q <= cpu_flags;
            tk_ch_q   <= win_ch;
        end
    end

    // Entry and return sequencer
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_q <= SQ_IDLE;
        end else begin
            unique case (st_q)
                SQ_IDLE:    st_q <= take ? SQ_PSH_PCL : (ret ? SQ_POP_FLG : SQ_IDLE);
                SQ_PSH_PCL: st_q <= SQ_PSH_PCH;
                SQ_PSH_PCH: st_q <= extended_context_bit ? SQ_PSH_CSR : SQ_PSH_FLG;
                SQ_PSH_CSR: st_q <= SQ_PSH_FLG;
                SQ_PSH_FLG: st_q <= SQ_VEC_RD;
                SQ_VEC_RD:  st_q <= SQ_VEC_WT;
                SQ_VEC_WT:  st_q <= SQ_VEC_LD;
                SQ_VEC_LD:  st_q <= SQ_IDLE;
                SQ_POP_FLG: st_q <= extended_context_bit ? SQ_POP_CSR : SQ_POP_PCH;
                SQ_POP_CSR: st_q <= SQ_POP_PCH;
                SQ_POP_PCH: st_q <= SQ_POP_PCL;
                SQ_POP_PCL: st_q <= SQ_POP_WT;
                SQ_POP_WT:  st_q <= SQ_RET_FIN;
                SQ_RET_FIN: st_q <= SQ_IDLE;
                default:    st_q <= SQ_IDLE;
            endcase
        end
    end

    // Stack write strobe and byte
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            stack_wr    <= 1'b0;
            stack_wdata <= `NIEC_RST_ZERO;
        end else begin
            stack_wr <= st_q inside {SQ_PSH_PCL, SQ_PSH_PCH, SQ_PSH_CSR, SQ_PSH_FLG};
            unique case (st_q)
                SQ_PSH_PCL: stack_wdata <= pc_sav_q[7:0];
                SQ_PSH_PCH: stack_wdata <= pc_sav_q[15:8];
                SQ_PSH_CSR: stack_wdata <= cseg_q;
                SQ_PSH_FLG: stack_wdata <= flg_sav_q;
                default:    stack_wdata <= stack_wdata;
            endcase
        end
    end

    // Stack read strobe and pop kind pipeline
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            stack_rd <= 1'b0;
            pk_q     <= PK_NONE;
            pk2_q    <= PK_NONE;
        end else begin
            stack_rd <= st_q inside {SQ_POP_FLG, SQ_POP_CSR, SQ_POP_PCH, SQ_POP_PCL};
            pk2_q    <= pk_q;
            unique case (st_q)
                SQ_POP_FLG: pk_q <= PK_FLG;
                SQ_POP_CSR: pk_q <= PK_CSR;
                SQ_POP_PCH: pk_q <= PK_PCH;
                SQ_POP_PCL: pk_q <= PK_PCL;
                default:    pk_q <= PK_NONE;
            endcase
        end
    end

    // Vector fetch: table entry chosen by vector register and channel
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            vec_rd   <= 1'b0;
            vec_addr <= `NIEC_RST_ZERO;
        end else begin
            vec_rd <= (st_q == SQ_VEC_RD);
            if (st_q == SQ_VEC_RD) begin
                vec_addr <= {ivr_q[7:4], tk_ch_q, 1'b0};
            end
        end
    end

    // PC and flags loads toward the core
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pc_load     <= 1'b0;
            pc_value    <= 16'h0000;
            flags_load  <= 1'b0;
            flags_value <= `NIEC_RST_ZERO;
            pch_q       <= `NIEC_RST_ZERO;
        end else begin
            pc_load    <= (st_q == SQ_VEC_LD) || (st_q == SQ_RET_FIN);
            flags_load <= (pk2_q == PK_FLG);
            if (st_q == SQ_VEC_LD) begin
                pc_value <= vec_rdata;
            end else if (st_q == SQ_RET_FIN) begin
                pc_value <= {pch_q, stack_rdata};
            end
            if (pk2_q == PK_FLG) begin
                flags_value <= stack_rdata;
            end
            if (pk2_q == PK_PCH) begin
                pch_q <= stack_rdata;
            end
        end
    end

    // Code segment, segment swap and service depth
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cseg_q     <= `NIEC_RST_ZERO;
            use_iseg_q <= 1'b0;
            depth_q    <= 4'h0;
        end else begin
            if (st_q == SQ_VEC_LD) begin
                depth_q <= depth_q + 4'h1;
                if (extended_context_bit) begin
                    cseg_q <= iseg_q;
                end else begin
                    use_iseg_q <= 1'b1;
                end
            end else if (st_q == SQ_RET_FIN) begin
                depth_q <= (depth_q == 4'h0) ? 4'h0 : depth_q - 4'h1;
                // Stay on the interrupt segment while an outer routine is live
                if (!extended_context_bit && depth_q <= 4'h1) begin
                    use_iseg_q <= 1'b0;
                end
            end else if (pk2_q == PK_CSR) begin
                cseg_q <= stack_rdata;
            end else if (bus_req.wr && bus_req.addr == `NIEC_OFS_CSEG) begin
                cseg_q <= bus_req.wdata;
            end
        end
    end

    // Segment the core fetches from
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            exec_segment <= `NIEC_RST_ZERO;
            seq_busy     <= 1'b0;
        end else begin
            exec_segment <= use_iseg_q ? iseg_q : cseg_q;
            seq_busy     <= (st_q != SQ_IDLE) || take || ret;
        end
    end

    // Read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bus_rdata <= `NIEC_RST_ZERO;
        end else if (bus_req.rd) begin
            unique case (bus_req.addr)
                `NIEC_OFS_CTRL: bus_rdata <= {3'h0, ien_q, iam_q, cpl_q};
                `NIEC_OFS_EDGE: bus_rdata <= edge_sel_q;
                `NIEC_OFS_PEND: bus_rdata <= pend_q;
                `NIEC_OFS_MASK: bus_rdata <= mask_q;
                `NIEC_OFS_PRIO: bus_rdata <= prio_q;
                `NIEC_OFS_NEST: bus_rdata <= nest_q;
                `NIEC_OFS_SRC:  bus_rdata <= src_q;
                `NIEC_OFS_ISEG: bus_rdata <= iseg_q;
                `NIEC_OFS_VEC:  bus_rdata <= ivr_q;
                `NIEC_OFS_CSEG: bus_rdata <= cseg_q;
                default:        bus_rdata <= `NIEC_RST_ZERO;
            endcase
        end else begin
            bus_rdata <= `NIEC_RST_ZERO;
        end
    end

endmodule
`default_nettype wire

/* File: sim/niec_chk.sv */
// Port-level assertions for the interrupt block
`default_nettype none
module niec_chk (
    // Clock, reset, register port
    input wire logic                sys_clk, rst_n,
    input wire niec_pkg::niec_bus_s bus_req,
    input wire logic [7:0]          bus_rdata,
    // Core handshake
    input wire logic                cpu_accept, cpu_iret, irq_req, seq_busy,
    input wire logic [15:0]         cpu_pc, vec_rdata, pc_value,
    // Stack, vector, context
    input wire logic                stack_wr, stack_rd, vec_rd, pc_load, flags_load,
    input wire logic [7:0]          stack_wdata, stack_rdata, vec_addr, flags_value
);
    timeunit 1ns;
    timeprecision 1ps;
    import niec_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    rdata_slot_a: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
        else $error("read data outside its slot");
    push_order_a: assert property (cpu_accept && irq_req |-> ##2 stack_wr
        && stack_wdata == $past(cpu_pc[7:0], 2) ##1 stack_wr && stack_wdata == $past(cpu_pc[15:8], 3))
        else $error("entry push order wrong");
    entry_nopop_a: assert property (cpu_accept && irq_req |=> !stack_rd [*8])
        else $error("pop during entry");
    vec_even_a: assert property (vec_rd |-> !vec_addr[0] && !stack_wr) else $error("odd vector address");
    vec_load_a: assert property (vec_rd |-> ##2 pc_load && pc_value == $past(vec_rdata))
        else $error("vector not loaded");
    iret_pop_a: assert property (cpu_iret && !cpu_accept && !seq_busy |-> ##2 stack_rd && !stack_wr)
        else $error("return does not pop");
    flags_take_a: assert property (flags_load |-> flags_value == $past(stack_rdata))
        else $error("flags not from stack");
    port_excl_a: assert property (!(stack_wr && stack_rd) && !(pc_load && vec_rd))
        else $error("stack strobes overlap");
    // Main scenarios reached
    cov_entry: cover property (cpu_accept && irq_req);
    cov_ret: cover property (flags_load ##2 pc_load);
    cov_rd: cover property (bus_req.rd ##1 bus_rdata != 8'h00);
endmodule
bind niec_top niec_chk u_chk (.*);
`default_nettype wire

/* File: sim/niec_core_mdl.sv */
// Stack memory and vector table on the core side
`default_nettype none
module niec_core_mdl (
    // Clock
    input wire logic         sys_clk,
    // Stack port
    input wire logic         stack_wr, stack_rd,
    input wire logic [7:0]   stack_wdata,
    output logic [7:0]       stack_rdata,
    // Vector table port
    input wire logic         vec_rd,
    input wire logic [7:0]   vec_addr,
    output logic [15:0]      vec_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem_q [16]; // Stack bytes
    logic [3:0] sp_q;       // Next free slot
    initial begin
        sp_q = 4'h0;
        stack_rdata = 8'h00;
        vec_rdata = 16'h0000;
    end
    // Answer one cycle after a strobe; otherwise scramble so stale data never passes
    always @(posedge sys_clk) begin
        stack_rdata <= ~stack_rdata;
        vec_rdata <= ~vec_rdata;
        if (stack_wr) begin
            mem_q[sp_q] <= stack_wdata;
            sp_q <= sp_q + 4'h1;
        end
        if (stack_rd) begin
            stack_rdata <= mem_q[sp_q - 4'h1];
            sp_q <= sp_q - 4'h1;
        end
        if (vec_rd) vec_rdata <= {8'ha5, vec_addr};
    end
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench for the interrupt block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import niec_pkg::*;
    typedef struct { logic [7:0] a, d, e; } niec_row_s;
    logic sys_clk = 1'b0, rst_n = 1'b0, cpu_accept = 1'b0, cpu_iret = 1'b0;
    niec_bus_s bus = '0;
    logic [6:0] isrc = '0; // Watchdog, timers, serial, converter, blanking, field
    logic [7:0] ext_pin = '0, bus_rdata, stack_wdata, stack_rdata, vec_addr, flags_value, exec_segment;
    logic [15:0] cpu_pc = 16'h1234, vec_rdata, pc_value;
    logic irq_req, seq_busy, stack_wr, stack_rd, vec_rd, pc_load, flags_load;
    int error_cnt = 0, n_checks = 0, cyc = 0;
    // Write row, then read back expecting the last column
    niec_row_s rows [7] = '{'{8'hf2, 8'h5a, 8'h5a}, '{8'hf3, 8'ha5, 8'ha5}, '{8'hf4, 8'h81, 8'h81},
        '{8'hf5, 8'h1b, 8'h1b}, '{8'hf9, 8'h44, 8'h44}, '{8'hfa, 8'h80, 8'h80}, '{8'h10, 8'h33, 8'h00}};
    always #5 sys_clk = ~sys_clk;
    niec_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus), .bus_rdata(bus_rdata), .ext_pin(ext_pin),
        .wdt_irq(isrc[0]), .tim0_irq(isrc[1]), .tim1_irq(isrc[2]), .spi_irq(isrc[3]), .adc_irq(isrc[4]),
        .end_of_vertical_blanking(isrc[5]), .field_start_event(isrc[6]), .cpu_accept(cpu_accept),
        .cpu_iret(cpu_iret), .cpu_pc(cpu_pc), .cpu_flags(8'h5c), .irq_req(irq_req), .seq_busy(seq_busy),
        .stack_wr(stack_wr), .stack_rd(stack_rd), .stack_wdata(stack_wdata), .stack_rdata(stack_rdata),
        .vec_rd(vec_rd), .vec_addr(vec_addr), .vec_rdata(vec_rdata), .pc_load(pc_load), .pc_value(pc_value),
        .flags_load(flags_load), .flags_value(flags_value), .exec_segment(exec_segment));
    niec_core_mdl u_core (.sys_clk(sys_clk), .stack_wr(stack_wr), .stack_rd(stack_rd), .stack_wdata(stack_wdata),
        .stack_rdata(stack_rdata), .vec_rd(vec_rd), .vec_addr(vec_addr), .vec_rdata(vec_rdata));
    task automatic chk(input logic [15:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge sys_clk) bus <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk) bus.wr <= 1'b0;
    endtask
    // Read data is looked at only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, e);
        @(posedge sys_clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge sys_clk) bus.rd <= 1'b0;
        #1 chk(bus_rdata, e);
    endtask
    // Entry or return strobe, then PC load and segment; waits bounded by the ceiling below
    task automatic run_seq(input logic iret, input logic [15:0] pc_e, input logic [7:0] seg_e);
        @(posedge sys_clk) {cpu_iret, cpu_accept} <= {iret, ~iret};
        @(posedge sys_clk) {cpu_iret, cpu_accept} <= 2'b00;
        while (pc_load !== 1'b1) @(negedge sys_clk);
        chk(pc_value, pc_e);
        chk(seq_busy, 1'b1);
        @(negedge sys_clk) chk(exec_segment, seg_e);
        chk(seq_busy, 1'b0);
    endtask
    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Cut a hang short well above the expected run of under two hundred cycles
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            end_sim();
        end
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        rdc(8'he6, 8'h07);
        rdc(8'hf8, 8'h03);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rdc(rows[i].a, rows[i].e);
        end
        // All internal sources selected, rising edges
        wr(8'hf3, 8'h00); wr(8'hf2, 8'hff); wr(8'hf8, 8'h74);
        @(posedge sys_clk) isrc <= 7'h7f;
        repeat (3) @(posedge sys_clk);
        rdc(8'hf3, 8'h7f);
        // Pins again: only pin 0 rising, the rest falling
        wr(8'hf8, 8'h03); wr(8'hf3, 8'h00); wr(8'hf2, 8'h01);
        @(posedge sys_clk) ext_pin <= 8'hff;
        repeat (5) @(posedge sys_clk);
        rdc(8'hf3, 8'h01);
        @(posedge sys_clk) ext_pin <= 8'h01;
        repeat (5) @(posedge sys_clk);
        rdc(8'hf3, 8'hff);
        // Nested entry of channel A0 at level 2; enable only in nested mode
        wr(8'hf3, 8'h01); wr(8'hf4, 8'h80); wr(8'hf5, 8'h40); wr(8'he6, 8'h1f);
        while (irq_req !== 1'b1) @(negedge sys_clk);
        run_seq(1'b0, 16'ha580, 8'h44);
        rdc(8'he6, 8'h0a);
        rdc(8'hf7, 8'h80);
        // Return restores everything
        run_seq(1'b1, 16'h1234, 8'h00);
        chk(flags_value, 8'h5c);
        rdc(8'he6, 8'h1f);
        rdc(8'hf7, 8'h00);
        // A1 at level 7 is never taken, at level 5 it is
        wr(8'hf5, 8'hc0); wr(8'hf4, 8'h40); wr(8'hf3, 8'h02);
        repeat (4) @(negedge sys_clk);
        chk(irq_req, 1'b0);
        wr(8'hf5, 8'ha0);
        repeat (4) @(negedge sys_clk);
        chk(irq_req, 1'b1);
        // Concurrent entry with context: A1 beats B1 at one level, level kept, segment saved
        wr(8'hf8, 8'h83); wr(8'hfb, 8'h21); wr(8'hf4, 8'h50); wr(8'hf3, 8'h0a); wr(8'he6, 8'h17);
        run_seq(1'b0, 16'ha582, 8'h44);
        rdc(8'he6, 8'h07);
        rdc(8'hf3, 8'h08);
        run_seq(1'b1, 16'h1234, 8'h21);
        rdc(8'he6, 8'h17);
        // Reset in mid-run clears flags and restores control
        @(posedge sys_clk) rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        rdc(8'hf3, 8'h00);
        rdc(8'he6, 8'h07);
        end_sim();
    end
endmodule
`default_nettype wire
